// >>> sfsa_bench.sv
// Purpose: Self-checking bench for the status and address mode block.
// Assumes: The host model frames every transfer at a 160 ns serial clock.
// Notes:   The status write cycle is shortened to WCYC system clocks.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module sfsa_bench;
    localparam int unsigned WCYC = 300;
    logic        clk_sys_i    = 1'b0;
    logic        sys_rst_i    = 1'b1;
    logic        hw_reset_n_i = 1'b1;
    logic        spi_cs_n_i;
    logic        spi_clk_i;
    logic        serial_in_i;
    logic        serial_out_o;
    logic        serial_out_en_n_o;
    logic [15:0] rx;
    int          err_total    = 0;
    int          check_count  = 0;
    wire         so_line      = serial_out_en_n_o ? 1'b1 : serial_out_o;

    always #5 clk_sys_i = ~clk_sys_i;

    sfsa_core #(.STATUS_WRITE_CYCLES(WCYC)) dut (
        .clk_sys_i         (clk_sys_i),
        .sys_rst_i         (sys_rst_i),
        .spi_cs_n_i        (spi_cs_n_i),
        .spi_clk_i         (spi_clk_i),
        .serial_in_i       (serial_in_i),
        .hw_reset_n_i      (hw_reset_n_i),
        .serial_out_o      (serial_out_o),
        .serial_out_en_n_o (serial_out_en_n_o)
    );

    sfsa_host host (
        .clk_sys_i (clk_sys_i),
        .so_i      (so_line),
        .cs_n_o    (spi_cs_n_i),
        .sclk_o    (spi_clk_i),
        .si_o      (serial_in_i)
    );

    task automatic wr(input logic [39:0] tx, input int nb);
        host.xfer(tx, nb, 0, rx);
    endtask

    // Reads n copies of a register and compares each with exp.
    task automatic rd(input logic [7:0] op, input int n, input logic [7:0] exp);
        host.xfer({32'h0, op}, 1, n, rx);
        `CHK(rx, (n == 2) ? {exp, exp} : {8'h00, exp})
    endtask

    task automatic t_power_up;
        rd(sfsa_pkg::OP_READ_SR1, 2, 8'h00);
        rd(sfsa_pkg::OP_READ_SR2, 2, 8'h00);
        rd(sfsa_pkg::OP_READ_SR3, 2, 8'h00);
        rd(sfsa_pkg::OP_READ_EAR, 2, sfsa_pkg::EAR_RESET);
    endtask

    task automatic t_latch;
        wr(40'h06, 1);
        rd(8'h05, 1, 8'h02);
        wr(40'h04, 1);
        rd(8'h05, 1, 8'h00);
        wr(40'h50, 1);
        rd(8'h05, 1, 8'h00);
        wr(40'h04, 1);
        wr(40'h01FF, 2);
        rd(8'h05, 1, 8'h00);
    endtask

    task automatic t_nv_write;
        wr(40'h06, 1);
        wr(40'h31FF, 2);
        rd(8'h05, 1, 8'h03);
        rd(8'h05, 2, 8'h00);
        rd(8'h35, 2, sfsa_pkg::SR_WRITE_MASK[1]);
    endtask

    task automatic t_vol_write;
        wr(40'h50, 1);
        wr(40'h3100, 2);
        rd(8'h35, 1, sfsa_pkg::SR_OTP_MASK[1]);
        rd(8'h05, 1, 8'h00);
        wr(40'h50, 1);
        wr(40'h01FFFF, 3);
        rd(8'h05, 1, sfsa_pkg::SR_WRITE_MASK[0]);
        rd(8'h35, 1, 8'h7B);
        wr(40'h50, 1);
        wr(40'h0100, 2);
        rd(8'h05, 1, 8'h00);
        rd(8'h35, 1, 8'h7B);
        wr(40'h50, 1);
        wr(40'h11FF, 2);
        rd(8'h15, 1, sfsa_pkg::SR_WRITE_MASK[2]);
        wr(40'h06, 1);
        wr(40'h66, 1);
        wr(40'h99, 1);
        rd(8'h15, 1, 8'h00);
        rd(8'h05, 1, 8'h00);
    endtask

    task automatic t_upper_byte;
        wr(40'hC512, 2);
        rd(8'hC8, 1, 8'h00);
        wr(40'h06, 1);
        wr(40'hC5A5, 2);
        rd(8'hC8, 1, 8'hA5);
        wr(40'hB7, 1);
        rd(8'h15, 1, 8'h01);
        wr(40'h033C000000, 5);
        rd(8'hC8, 1, 8'h3C);
        wr(40'hE9, 1);
        rd(8'h15, 1, 8'h00);
        rd(8'hC8, 1, 8'h3C);
    endtask

    // Volatile values are changed first so that the pin reset has something to undo.
    task automatic t_hw_reset;
        wr(40'h50, 1);
        wr(40'h3100, 2);
        rd(8'h35, 1, sfsa_pkg::SR_OTP_MASK[1]);
        wr(40'h50, 1);
        wr(40'h1166, 2);
        rd(8'h15, 1, 8'h66);
        host.tick(1);
        hw_reset_n_i = 1'b0;
        host.tick(6);
        hw_reset_n_i = 1'b1;
        host.tick(6);
        rd(8'h35, 1, 8'h7B);
        rd(8'h15, 1, 8'h00);
        rd(8'hC8, 1, 8'h00);
        rd(8'h05, 1, 8'h00);
    endtask

    task automatic test_done;
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        host.tick(4);
        sys_rst_i = 1'b0;
        host.tick(4);
        t_power_up();
        t_latch();
        t_nv_write();
        t_vol_write();
        t_upper_byte();
        t_hw_reset();
        test_done();
    end

    initial
    begin
        #500000;
        err_total++;
        test_done();
    end
endmodule

// >>> sfsa_checker.sv
// Purpose: Port-level assertions for the status and address mode block.
// Assumes: The serial clock is much slower than clk_sys_i.
// Notes:   Bound to every instance of sfsa_core.
`timescale 1ns/1ps
module sfsa_checker #(
    parameter int unsigned STATUS_WRITE_CYCLES = 1000
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_clk_i,
    input wire logic serial_in_i,
    input wire logic hw_reset_n_i,
    input wire logic serial_out_o,
    input wire logic serial_out_en_n_o
);
    logic       sclk_q;
    logic [3:0] since_fall;
    logic [4:0] rise_cnt;
    logic [3:0] cs_high_cnt;

    // Counters of serial clock edges and of chip select idle time.
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            sclk_q      <= 1'b0;
            since_fall  <= 4'hF;
            rise_cnt    <= 5'h00;
            cs_high_cnt <= 4'hF;
        end
        else
        begin
            sclk_q      <= spi_clk_i;
            since_fall  <= (sclk_q && !spi_clk_i) ? 4'h0
                         : since_fall + {3'h0, since_fall != 4'hF};
            rise_cnt    <= spi_cs_n_i ? 5'h00
                         : rise_cnt + {4'h0, !sclk_q && spi_clk_i && rise_cnt != 5'h1F};
            cs_high_cnt <= !spi_cs_n_i ? 4'h0
                         : cs_high_cnt + {3'h0, cs_high_cnt != 4'hF};
        end
    end

    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_reset_quiet: assert property ($fell(sys_rst_i) |-> serial_out_en_n_o && !serial_out_o)
        else $error("output active after reset");
    chk_en_frame: assert property (!serial_out_en_n_o |-> cs_high_cnt <= 4'h6)
        else $error("output enabled outside a frame");
    chk_out_at_fall: assert property ($changed(serial_out_o) && !serial_out_en_n_o
        && $past(!serial_out_en_n_o) |-> since_fall inside {[4'h2:4'h6]})
        else $error("read bit changed away from a serial clock fall");
    chk_en_start_fall: assert property ($fell(serial_out_en_n_o) |-> since_fall inside {[4'h2:4'h6]})
        else $error("output enable not tied to a serial clock fall");
    chk_en_after_byte: assert property ($fell(serial_out_en_n_o) |-> rise_cnt >= 5'h08)
        else $error("output enabled before a whole opcode");
    chk_en_release: assert property ($rose(spi_cs_n_i) |-> ##[1:6] serial_out_en_n_o)
        else $error("output not released after chip select rise");
    chk_en_end_cs: assert property ($rose(serial_out_en_n_o) |-> cs_high_cnt >= 4'h2)
        else $error("read stopped while chip select low");
    chk_idle_quiet: assert property (spi_cs_n_i [*8] |-> serial_out_en_n_o)
        else $error("output enabled while deselected");

    cov_read_out: cover property ($fell(serial_out_en_n_o));
    cov_frame_end: cover property ($rose(spi_cs_n_i));
    cov_hw_reset: cover property ($fell(hw_reset_n_i));
endmodule

bind sfsa_core sfsa_checker #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_chk (
    .clk_sys_i         (clk_sys_i),
    .sys_rst_i         (sys_rst_i),
    .spi_cs_n_i        (spi_cs_n_i),
    .spi_clk_i         (spi_clk_i),
    .serial_in_i       (serial_in_i),
    .hw_reset_n_i      (hw_reset_n_i),
    .serial_out_o      (serial_out_o),
    .serial_out_en_n_o (serial_out_en_n_o)
);

// >>> sfsa_core.sv
// Purpose: Instruction handling for write enable, status registers, upper address byte
//          and address mode inside a serial flash device.
// Assumes: Chip select, serial clock, serial_in and the reset pin are asynchronous and
//          are sampled by clk_sys_i; the serial clock is much slower than clk_sys_i.
// Notes:   Array read, program and erase are outside this block; only the top address
//          byte of their address phase is observed.
`timescale 1ns/1ps

module sfsa_core #(
    parameter int unsigned STATUS_WRITE_CYCLES =
        sfsa_pkg::STATUS_WRITE_TIME_NS / sfsa_pkg::CLK_PERIOD_NS
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_clk_i,
    input  wire logic serial_in_i,
    input  wire logic hw_reset_n_i,
    output logic      serial_out_o,
    output logic      serial_out_en_n_o
);

    sfsa_pkg::sfsa_state_t st;
    sfsa_pkg::sfsa_state_t next_st;

    logic            cs_hi;
    logic            cs_rise;
    logic            cs_fall;
    logic            clk_rise;
    logic            clk_fall;
    logic            busy;
    logic            hw_rst;
    logic [7:0]      byte_in;
    logic [7:0]      rd_val;
    logic [2:0]      wsel;
    logic [2:0][7:0] view;
    logic [2:0][7:0] wdata;
    logic [2:0][7:0] vol_merge;
    logic [2:0][7:0] nv_merge;

    // Keeps protected bits, takes writable bits, and never lets one-time bits fall.
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                         input logic [7:0] wmask, input logic [7:0] otp);
        merge = ((old & ~wmask) | (data & wmask)) | (old & otp);
    endfunction

    function automatic logic is_addr_op(input logic [7:0] op);
        is_addr_op = 1'b0;
        for (int k = 0; k < sfsa_pkg::ADDR_OP_COUNT; k++)
        begin
            if (sfsa_pkg::ADDR_OPS[k] == op)
            begin
                is_addr_op = 1'b1;
            end
        end
    endfunction

    // Reload after power-up or reset; sync stages and frame state are kept by caller.
    function automatic sfsa_pkg::sfsa_state_t apply_reset(input sfsa_pkg::sfsa_state_t s);
        sfsa_pkg::sfsa_state_t r;
        r                    = s;
        r.vol                = s.nv;
        r.ear                = sfsa_pkg::EAR_RESET;
        r.write_enable_latch = 1'b0;
        r.vol_armed          = 1'b0;
        r.rst_armed          = 1'b0;
        r.addr_mode_flag     = s.nv[2][sfsa_pkg::SR3_ADP_BIT];
        r.dev                = sfsa_pkg::DEV_READY;
        r.wcnt               = '0;
        r.pend_sel           = 3'h0;
        apply_reset          = r;
    endfunction

    assign cs_hi    = st.cs_sync[1];
    assign cs_rise  = st.cs_sync[1] & ~st.cs_sync[2];
    assign cs_fall  = ~st.cs_sync[1] & st.cs_sync[2];
    assign clk_rise = st.clk_sync[1] & ~st.clk_sync[2];
    assign clk_fall = ~st.clk_sync[1] & st.clk_sync[2];
    assign busy     = (st.dev == sfsa_pkg::DEV_WRITING);
    assign hw_rst   = ~st.rst_sync[1];
    assign byte_in  = {st.shift[6:0], st.si_sync[1]};

    // Live views: busy, latch and address mode are shown inside the registers.
    always_comb
    begin
        view                               = st.vol;
        view[0][sfsa_pkg::SR1_BUSY_BIT]    = busy;
        view[0][sfsa_pkg::SR1_WEL_BIT]     = st.write_enable_latch;
        view[2][sfsa_pkg::SR3_ADS_BIT]     = st.addr_mode_flag;
    end

    always_comb
    begin
        case (st.opcode)
            sfsa_pkg::OP_READ_SR1: rd_val = view[0];
            sfsa_pkg::OP_READ_SR2: rd_val = view[1];
            sfsa_pkg::OP_READ_SR3: rd_val = view[2];
            default:               rd_val = st.ear;
        endcase
    end

    // Registers touched by a completed write frame.
    always_comb
    begin
        wsel = 3'h0;
        if (st.byte_cnt == sfsa_pkg::BYTE_DATA1)
        begin
            case (st.opcode)
                sfsa_pkg::OP_WRITE_SR1: wsel = 3'b001;
                sfsa_pkg::OP_WRITE_SR2: wsel = 3'b010;
                sfsa_pkg::OP_WRITE_SR3: wsel = 3'b100;
                default:                wsel = 3'h0;
            endcase
        end
        else if (st.byte_cnt == sfsa_pkg::BYTE_DATA2 && st.opcode == sfsa_pkg::OP_WRITE_SR1)
        begin
            wsel = 3'b011;
        end
    end

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_merge
            assign wdata[i] = (i == 1 && st.opcode == sfsa_pkg::OP_WRITE_SR1) ?
                              st.data1 : st.data0;
            assign vol_merge[i] = merge(st.vol[i], wdata[i], sfsa_pkg::SR_WRITE_MASK[i],
                                        sfsa_pkg::SR_OTP_MASK[i]);
            assign nv_merge[i]  = merge(st.nv[i], wdata[i], sfsa_pkg::SR_WRITE_MASK[i],
                                        sfsa_pkg::SR_OTP_MASK[i]);
        end
    endgenerate

    always_comb
    begin
        next_st          = st;
        next_st.cs_sync  = {st.cs_sync[1:0], spi_cs_n_i};
        next_st.clk_sync = {st.clk_sync[1:0], spi_clk_i};
        next_st.si_sync  = {st.si_sync[0], serial_in_i};
        next_st.rst_sync = {st.rst_sync[0], hw_reset_n_i};

        // Self-timed non-volatile write cycle.
        if (busy)
        begin
            if (st.wcnt == sfsa_pkg::WCNT_W'(STATUS_WRITE_CYCLES - 1))
            begin
                for (int k = 0; k < 3; k++)
                begin
                    if (st.pend_sel[k])
                    begin
                        next_st.nv[k]  = st.pend[k];
                        next_st.vol[k] = st.pend[k];
                    end
                end
                next_st.write_enable_latch = 1'b0;
                next_st.dev                = sfsa_pkg::DEV_READY;
                next_st.wcnt               = '0;
                next_st.pend_sel           = 3'h0;
            end
            else
            begin
                next_st.wcnt = st.wcnt + 1'b1;
            end
        end

        if (cs_fall)
        begin
            next_st.bit_idx  = 3'h0;
            next_st.byte_cnt = sfsa_pkg::BYTE_OPCODE;
            next_st.opcode   = 8'h00;
            next_st.so_en_n  = 1'b1;
        end
        else if (!cs_hi && clk_rise)
        begin
            next_st.shift   = byte_in;
            next_st.bit_idx = st.bit_idx + 1'b1;
            if (st.bit_idx == sfsa_pkg::BIT_LAST)
            begin
                if (st.byte_cnt == sfsa_pkg::BYTE_OPCODE)
                begin
                    next_st.opcode = byte_in;
                end
                else if (st.byte_cnt == sfsa_pkg::BYTE_DATA0)
                begin
                    next_st.data0 = byte_in;
                    if (st.addr_mode_flag && is_addr_op(st.opcode) && !busy)
                    begin
                        next_st.ear = byte_in;
                    end
                end
                else if (st.byte_cnt == sfsa_pkg::BYTE_DATA1)
                begin
                    next_st.data1 = byte_in;
                end
                if (st.byte_cnt != sfsa_pkg::BYTE_SAT)
                begin
                    next_st.byte_cnt = st.byte_cnt + 1'b1;
                end
            end
        end
        else if (!cs_hi && clk_fall && st.byte_cnt != sfsa_pkg::BYTE_OPCODE)
        begin
            if (st.opcode == sfsa_pkg::OP_READ_SR1 || st.opcode == sfsa_pkg::OP_READ_SR2 ||
                st.opcode == sfsa_pkg::OP_READ_SR3 || st.opcode == sfsa_pkg::OP_READ_EAR)
            begin
                next_st.so      = rd_val[sfsa_pkg::BIT_LAST - st.bit_idx];
                next_st.so_en_n = 1'b0;
            end
        end
        else if (cs_rise)
        begin
            next_st.so_en_n = 1'b1;
            if (!busy && st.bit_idx == 3'h0)
            begin
                if (st.opcode != sfsa_pkg::OP_VOL_WRITE_ENABLE &&
                    st.byte_cnt != sfsa_pkg::BYTE_OPCODE)
                begin
                    next_st.vol_armed = 1'b0;
                end
                if (st.opcode != sfsa_pkg::OP_RESET_ENABLE &&
                    st.byte_cnt != sfsa_pkg::BYTE_OPCODE)
                begin
                    next_st.rst_armed = 1'b0;
                end
                case (st.opcode)
                    sfsa_pkg::OP_WRITE_ENABLE:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA0)
                        begin
                            next_st.write_enable_latch = 1'b1;
                        end
                    end
                    sfsa_pkg::OP_VOL_WRITE_ENABLE:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA0)
                        begin
                            next_st.vol_armed = 1'b1;
                        end
                    end
                    sfsa_pkg::OP_WRITE_DISABLE:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA0)
                        begin
                            next_st.write_enable_latch = 1'b0;
                        end
                    end
                    sfsa_pkg::OP_WRITE_SR1, sfsa_pkg::OP_WRITE_SR2, sfsa_pkg::OP_WRITE_SR3:
                    begin
                        if (wsel != 3'h0 && st.vol_armed)
                        begin
                            for (int k = 0; k < 3; k++)
                            begin
                                if (wsel[k])
                                begin
                                    next_st.vol[k] = vol_merge[k];
                                end
                            end
                        end
                        else if (wsel != 3'h0 && st.write_enable_latch)
                        begin
                            next_st.pend     = nv_merge;
                            next_st.pend_sel = wsel;
                            next_st.dev      = sfsa_pkg::DEV_WRITING;
                            next_st.wcnt     = '0;
                        end
                    end
                    sfsa_pkg::OP_WRITE_EAR:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA1 &&
                            st.write_enable_latch)
                        begin
                            next_st.ear = st.data0;
                        end
                    end
                    sfsa_pkg::OP_ENTER_4B:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA0)
                        begin
                            next_st.addr_mode_flag = 1'b1;
                        end
                    end
                    sfsa_pkg::OP_EXIT_4B:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA0)
                        begin
                            next_st.addr_mode_flag = 1'b0;
                        end
                    end
                    sfsa_pkg::OP_RESET_ENABLE:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA0)
                        begin
                            next_st.rst_armed = 1'b1;
                        end
                    end
                    sfsa_pkg::OP_RESET:
                    begin
                        if (st.byte_cnt == sfsa_pkg::BYTE_DATA0 && st.rst_armed)
                        begin
                            next_st = apply_reset(next_st);
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end

        if (hw_rst)
        begin
            next_st = apply_reset(next_st);
        end

        if (sys_rst_i)
        begin
            next_st          = st;
            next_st.cs_sync  = 3'h7;
            next_st.clk_sync = 3'h0;
            next_st.si_sync  = 2'h0;
            next_st.rst_sync = 2'h3;
            next_st.bit_idx  = 3'h0;
            next_st.byte_cnt = sfsa_pkg::BYTE_OPCODE;
            next_st.shift    = 8'h00;
            next_st.opcode   = 8'h00;
            next_st.data0    = 8'h00;
            next_st.data1    = 8'h00;
            next_st.nv       = sfsa_pkg::SR_NV_INIT;
            next_st.pend     = sfsa_pkg::SR_NV_INIT;
            next_st.so       = 1'b0;
            next_st.so_en_n  = 1'b1;
            next_st          = apply_reset(next_st);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        st <= next_st;
    end

    assign serial_out_o      = st.so;
    assign serial_out_en_n_o = st.so_en_n;

endmodule

// >>> sfsa_host.sv
// Purpose: Behavioural SPI host that frames instructions for the flash block.
// Assumes: Mode 0; serial clock period 16 system clocks, still between frames.
// Notes:   The data line shows the inverse of its last bit when not in use.
`timescale 1ns/1ps
module sfsa_host (
    input  wire logic clk_sys_i,
    input  wire logic so_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      si_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // Sends nb bytes MSB first inside one chip select frame, then reads rb bytes.
    task automatic xfer(input logic [39:0] tx, input int nb, input int rb,
                        output logic [15:0] rx);
        rx     = 16'h0000;
        cs_n_o = 1'b0;
        tick(8);
        for (int i = 8 * (nb + rb) - 1; i >= 0; i--)
        begin
            si_o = (i >= 8 * rb) ? tx[i - 8 * rb] : ~si_o;
            tick(8);
            sclk_o = 1'b1;
            if (i < 8 * rb)
                rx = {rx[14:0], so_i};
            tick(8);
            sclk_o = 1'b0;
        end
        tick(8);
        cs_n_o = 1'b1;
        si_o   = ~si_o;
        tick(8);
    endtask
endmodule

// >>> sfsa_pkg.sv
// Purpose: Shared constants and types for the serial flash status and address mode block.
// Assumes: Single system clock at 100 MHz; link pins are sampled, not used as clocks.
// Notes:   Status register bit positions and masks are kept here for core and bench.
package sfsa_pkg;

    // Instruction codes.
    localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
    localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
    localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
    localparam logic [7:0] OP_READ_SR1         = 8'h05;
    localparam logic [7:0] OP_READ_SR2         = 8'h35;
    localparam logic [7:0] OP_READ_SR3         = 8'h15;
    localparam logic [7:0] OP_WRITE_SR1        = 8'h01;
    localparam logic [7:0] OP_WRITE_SR2        = 8'h31;
    localparam logic [7:0] OP_WRITE_SR3        = 8'h11;
    localparam logic [7:0] OP_READ_EAR         = 8'hC8;
    localparam logic [7:0] OP_WRITE_EAR        = 8'hC5;
    localparam logic [7:0] OP_ENTER_4B         = 8'hB7;
    localparam logic [7:0] OP_EXIT_4B          = 8'hE9;
    localparam logic [7:0] OP_RESET_ENABLE     = 8'h66;
    localparam logic [7:0] OP_RESET            = 8'h99;

    // Array instructions whose first address byte is the top byte in 4-byte mode.
    localparam int unsigned ADDR_OP_COUNT = 11;
    localparam logic [ADDR_OP_COUNT-1:0][7:0] ADDR_OPS =
        {8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h02, 8'h32, 8'h20, 8'h52, 8'hD8};

    // Status bit positions.
    localparam int unsigned SR1_BUSY_BIT = 0;
    localparam int unsigned SR1_WEL_BIT  = 1;
    localparam int unsigned SR3_ADS_BIT  = 0;
    localparam int unsigned SR3_ADP_BIT  = 1;

    // Register index 0, 1, 2 holds status register one, two, three.
    localparam logic [2:0][7:0] SR_WRITE_MASK = {8'h66, 8'h7B, 8'h7C};
    localparam logic [2:0][7:0] SR_OTP_MASK   = {8'h00, 8'h39, 8'h00};
    localparam logic [2:0][7:0] SR_NV_INIT    = {8'h00, 8'h00, 8'h00};
    localparam logic [7:0]      EAR_RESET     = 8'h00;

    // Byte counter codes inside one frame.
    localparam logic [2:0] BYTE_OPCODE = 3'h0;
    localparam logic [2:0] BYTE_DATA0  = 3'h1;
    localparam logic [2:0] BYTE_DATA1  = 3'h2;
    localparam logic [2:0] BYTE_DATA2  = 3'h3;
    localparam logic [2:0] BYTE_SAT    = 3'h7;
    localparam logic [2:0] BIT_LAST    = 3'h7;

    // Timing.
    localparam int unsigned CLK_PERIOD_NS        = 10;
    localparam int unsigned STATUS_WRITE_TIME_NS = 10000;
    localparam int unsigned WCNT_W               = 24;

    typedef enum logic [1:0] {
        DEV_READY   = 2'b01,
        DEV_WRITING = 2'b10
    } sfsa_dev_state_t;

    typedef struct packed {
        logic [2:0]      cs_sync;
        logic [2:0]      clk_sync;
        logic [1:0]      si_sync;
        logic [1:0]      rst_sync;
        logic [2:0]      bit_idx;
        logic [2:0]      byte_cnt;
        logic [7:0]      shift;
        logic [7:0]      opcode;
        logic [7:0]      data0;
        logic [7:0]      data1;
        logic [2:0][7:0] vol;
        logic [2:0][7:0] nv;
        logic [2:0][7:0] pend;
        logic [2:0]      pend_sel;
        logic [7:0]      ear;
        logic            write_enable_latch;
        logic            vol_armed;
        logic            rst_armed;
        logic            addr_mode_flag;
        sfsa_dev_state_t dev;
        logic [WCNT_W-1:0] wcnt;
        logic            so;
        logic            so_en_n;
    } sfsa_state_t;

endpackage
